// >>> hw/frt_timer.sv
// Purpose: 16-bit free-running timer with capture and compare
// Assumes: one pclk domain; pins are synchronised inside
// Notes:   byte registers sit one per APB word, upper bits read zero
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module frt_timer (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clk_en,
    input  wire frt_pkg::frt_apb_req_s apb_req,
    output frt_pkg::frt_apb_rsp_s      apb_rsp,
    input  wire logic                  cpu_irq_mask,
    input  wire logic                  halt_mode,
    input  wire logic                  ext_clock_pin,
    input  wire logic [1:0]            capture_pin,
    output logic [1:0]                 compare_pin,
    output logic                       timer_irq
);
    import frt_pkg::*;

    frt_state_s st_ff;
    frt_state_s nxt_st;
    logic       acc_go;    // first access cycle, data is sampled here
    logic       done;      // completion edge of a transfer
    logic       rd_done;
    logic       wr_done;
    logic       tick;
    logic       div_tick;
    logic       ext_act;
    logic       ovf_set;
    logic [1:0] cap_ev;
    logic [1:0] cmp_hit;
    logic [1:0] cs;
    logic [7:0] a;
    logic [7:0] rdat;
    logic       rerr;

    // ****************************************************************
    // Next state
    // ****************************************************************

    // All timer behaviour in one pass over the state copy
    always_comb begin
        nxt_st   = st_ff;
        a        = apb_req.paddr;
        cs       = st_ff.ctl2[C2_CS_LO+1:C2_CS_LO];
        acc_go   = apb_req.psel & apb_req.penable & ~st_ff.rsp.pready;
        done     = apb_req.psel & apb_req.penable & st_ff.rsp.pready;
        rd_done  = done & ~apb_req.pwrite;
        wr_done  = done & apb_req.pwrite;
        rdat     = 8'h00;
        rerr     = 1'b0;
        cap_ev   = 2'b00;
        cmp_hit  = 2'b00;

        // Pin synchronisers; stage 0 feeds only stage 1
        nxt_st.ext_s = {st_ff.ext_s[1:0], ext_clock_pin};
        for (int i = 0; i < 2; i++) begin
            nxt_st.cap_s[i] = {st_ff.cap_s[i][1:0], capture_pin[i]};
        end

        // Prescaler runs off the CPU clock; halt freezes it
        if (!halt_mode) begin
            nxt_st.presc = st_ff.presc + 3'h1;
        end
        div_tick = (cs == CS_DIV2) ? st_ff.presc[0] :
                   (cs == CS_DIV4) ? &st_ff.presc[1:0] :
                                     &st_ff.presc;
        // Edge found on synchronised stages; spacing keeps one per edge
        ext_act  = (st_ff.ext_s[1] ^ st_ff.ext_s[2]) &
                   (st_ff.ext_s[1] == st_ff.ctl2[C2_EXEDGE]);
        tick     = ~halt_mode &
                   ((cs == CS_EXT) ? ext_act : div_tick);
        ovf_set  = tick & (st_ff.cnt == CNT_TOP);

        // Counter advances on the same CPU clock edge as all else
        if (tick) begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end

        // Compare each tick, ahead of the increment
        for (int i = 0; i < 2; i++) begin
            cmp_hit[i] = tick & ~st_ff.cmp_inh[i] &
                         (st_ff.cnt == st_ff.cmp[i]);
        end
        if (cmp_hit[0] && st_ff.ctl2[C2_PEN1]) begin
            nxt_st.pin[0] = st_ff.ctl1[C1_LVL1];
        end
        if (cmp_hit[1] && st_ff.ctl2[C2_PEN2]) begin
            nxt_st.pin[1] = st_ff.ctl1[C1_LVL2];
        end

        // Captures: pins always watched, blocked while high byte read
        for (int i = 0; i < 2; i++) begin
            cap_ev[i] = (st_ff.cap_s[i][1] ^ st_ff.cap_s[i][2]) &
                        (st_ff.cap_s[i][1] ==
                         ((i == 0) ? st_ff.ctl1[C1_EDGE1]
                                   : st_ff.ctl2[C2_EDGE2])) &
                        ~st_ff.cap_lock[i];
        end
        if (st_ff.ctl2[C2_OPM] || st_ff.ctl2[C2_PWM]) begin
            cap_ev[0] = 1'b0;
        end
        for (int i = 0; i < 2; i++) begin
            if (cap_ev[i]) begin
                nxt_st.cap[i] = st_ff.cnt;
            end
        end

        // Read data is sampled in the first access cycle
        nxt_st.rsp.pready = acc_go;
        if (acc_go) begin
            nxt_st.snap = st_ff.cnt;
            if (a == A_CTL1) begin
                rdat = st_ff.ctl1;
            end else if (a == A_CTL2) begin
                rdat = st_ff.ctl2;
            end else if (a == A_STAT) begin
                rdat[S_CAPF1] = st_ff.cap_f[0];
                rdat[S_CMPF1] = st_ff.cmp_f[0];
                rdat[S_OVF]   = st_ff.ovf;
                rdat[S_CAPF2] = st_ff.cap_f[1];
                rdat[S_CMPF2] = st_ff.cmp_f[1];
            end else if (a == A_CNT_HI || a == A_ALT_HI) begin
                rdat = st_ff.cnt[15:8];
            end else if (a == A_CNT_LO) begin
                rdat = st_ff.cnt_lock ? st_ff.cnt_buf
                                      : st_ff.cnt[7:0];
            end else if (a == A_ALT_LO) begin
                rdat = st_ff.alt_lock ? st_ff.alt_buf
                                      : st_ff.cnt[7:0];
            end else if (a == A_CAP_HI || a == A_CAP_HI + A_CH_STEP) begin
                // High bytes sit at 1C and 24, so bit 3 is inverted here
                rdat = st_ff.cap[~a[3]][15:8];
            end else if (a == A_CAP_LO || a == A_CAP_LO + A_CH_STEP) begin
                rdat = st_ff.cap[a[3]][7:0];
            end else if (a == A_CMP_HI || a == A_CMP_HI + A_CH_STEP) begin
                rdat = st_ff.cmp[~a[3]][15:8];
            end else if (a == A_CMP_LO || a == A_CMP_LO + A_CH_STEP) begin
                rdat = st_ff.cmp[a[3]][7:0];
            end else begin
                rerr = 1'b1;
            end
            nxt_st.rsp.prdata  = {24'h00_0000, rdat};
            nxt_st.rsp.pslverr = rerr;
        end

        // Status read arms the clear of flags it reported set
        if (rd_done && a == A_STAT) begin
            nxt_st.ovf_arm    = st_ff.rsp.prdata[S_OVF];
            nxt_st.cap_arm[0] = st_ff.rsp.prdata[S_CAPF1];
            nxt_st.cap_arm[1] = st_ff.rsp.prdata[S_CAPF2];
            nxt_st.cmp_arm[0] = st_ff.rsp.prdata[S_CMPF1];
            nxt_st.cmp_arm[1] = st_ff.rsp.prdata[S_CMPF2];
        end

        // Counter byte reads: high byte locks the low byte snapshot
        if (rd_done && a == A_CNT_HI && !st_ff.cnt_lock) begin
            nxt_st.cnt_buf  = st_ff.snap[7:0];
            nxt_st.cnt_lock = 1'b1;
        end
        if (rd_done && a == A_ALT_HI && !st_ff.alt_lock) begin
            nxt_st.alt_buf  = st_ff.snap[7:0];
            nxt_st.alt_lock = 1'b1;
        end
        if (rd_done && a == A_CNT_LO) begin
            nxt_st.cnt_lock = 1'b0;
        end
        if (rd_done && a == A_ALT_LO) begin
            nxt_st.alt_lock = 1'b0;
        end

        // Low byte writes restart the count from the one reload value
        if (wr_done && (a == A_CNT_LO || a == A_ALT_LO)) begin
            nxt_st.cnt   = CNT_RST;
            nxt_st.presc = 3'h0;
        end

        // Overflow: only the main low byte finishes the clear
        if (done && a == A_CNT_LO && st_ff.ovf_arm) begin
            nxt_st.ovf     = 1'b0;
            nxt_st.ovf_arm = 1'b0;
        end
        // Alternate low byte deliberately leaves the flag alone
        if (ovf_set) begin
            nxt_st.ovf = 1'b1;
        end

        // Capture channel byte accesses and flag clearing
        for (int i = 0; i < 2; i++) begin
            if (rd_done && a == A_CAP_HI + A_CH_STEP * 8'(i)) begin
                nxt_st.cap_lock[i] = 1'b1;
            end
            if (rd_done && a == A_CAP_LO + A_CH_STEP * 8'(i)) begin
                nxt_st.cap_lock[i] = 1'b0;
            end
            if (done && a == A_CAP_LO + A_CH_STEP * 8'(i) &&
                st_ff.cap_arm[i]) begin
                nxt_st.cap_f[i]   = 1'b0;
                nxt_st.cap_arm[i] = 1'b0;
            end
            if (cap_ev[i]) begin
                nxt_st.cap_f[i] = 1'b1;
            end
        end

        // Compare channels: high write inhibits until low write
        for (int i = 0; i < 2; i++) begin
            if (wr_done && a == A_CMP_HI + A_CH_STEP * 8'(i)) begin
                nxt_st.cmp[i][15:8] = apb_req.pwdata[7:0];
                nxt_st.cmp_inh[i]   = 1'b1;
            end
            if (wr_done && a == A_CMP_LO + A_CH_STEP * 8'(i)) begin
                nxt_st.cmp[i][7:0] = apb_req.pwdata[7:0];
                nxt_st.cmp_inh[i]  = 1'b0;
            end
            if (done && a == A_CMP_LO + A_CH_STEP * 8'(i) &&
                st_ff.cmp_arm[i]) begin
                nxt_st.cmp_f[i]   = 1'b0;
                nxt_st.cmp_arm[i] = 1'b0;
            end
            if (cmp_hit[i]) begin
                nxt_st.cmp_f[i] = 1'b1;
            end
        end

        // Control writes
        if (wr_done && a == A_CTL1) begin
            nxt_st.ctl1 = apb_req.pwdata[7:0];
        end
        if (wr_done && a == A_CTL2) begin
            nxt_st.ctl2 = apb_req.pwdata[7:0];
        end

        // Interrupt is a level that stays while an enabled source is pending and the CPU mask is clear
        nxt_st.irq = ~cpu_irq_mask &
                     ((st_ff.ovf & st_ff.ctl1[C1_OVF_IE]) |
                      (|st_ff.cap_f & st_ff.ctl1[C1_CAP_IE]) |
                      (|st_ff.cmp_f & st_ff.ctl1[C1_CMP_IE]));
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset loads the documented counter and compare values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= ST_RST;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign apb_rsp     = st_ff.rsp;
    assign compare_pin = st_ff.pin;
    assign timer_irq   = st_ff.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_lo_write;
        clk_en && wr_done && (a == A_CNT_LO || a == A_ALT_LO);
    endsequence

    sequence s_ovf_clear;
        clk_en && done && a == A_CNT_LO && st_ff.ovf_arm && !ovf_set;
    endsequence

    sequence s_alt_access;
        clk_en && done && a == A_ALT_LO && st_ff.ovf;
    endsequence

    a_reload_on_write: assert property (
        s_lo_write |=> st_ff.cnt == CNT_RST)
        else $error("counter not reloaded on low byte write");

    a_wrap_sets_ovf: assert property (
        clk_en && ovf_set &&
        !(wr_done && (a == A_CNT_LO || a == A_ALT_LO))
        |=> st_ff.ovf && st_ff.cnt == 16'h0000)
        else $error("wrap did not set overflow");

    a_ovf_irq_out: assert property (
        clk_en && st_ff.ovf && st_ff.ctl1[C1_OVF_IE] && !cpu_irq_mask
        |=> timer_irq)
        else $error("overflow interrupt missing");

    a_irq_masked: assert property (
        clk_en && cpu_irq_mask |=> !timer_irq)
        else $error("interrupt raised while masked");

    a_ext_count: assert property (
        clk_en && cs == CS_EXT && ext_act && !halt_mode && !wr_done
        |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
        else $error("external edge did not advance count");

    a_ovf_clear_pair: assert property (
        s_ovf_clear |=> !st_ff.ovf)
        else $error("overflow flag not cleared");

    a_alt_keeps_ovf: assert property (
        s_alt_access |=> st_ff.ovf)
        else $error("alternate access cleared overflow");

    a_halt_holds: assert property (
        clk_en && halt_mode && !(wr_done && (a == A_CNT_LO ||
                                             a == A_ALT_LO))
        |=> $stable(st_ff.cnt))
        else $error("counter moved in halt");

    a_capture_latch: assert property (
        clk_en && cap_ev[1] |=> st_ff.cap[1] == $past(st_ff.cnt)
                                && st_ff.cap_f[1])
        else $error("capture did not latch count");

    a_capture_block: assert property (
        clk_en && st_ff.cap_lock[0] |=> $stable(st_ff.cap[0]))
        else $error("capture taken while blocked");

    a_cap_flag_block: assert property (
        clk_en && st_ff.cap_lock[1] && !st_ff.cap_f[1]
        |=> !st_ff.cap_f[1])
        else $error("capture flag set while blocked");

    a_cmp_flag_set: assert property (
        clk_en && cmp_hit[0] |=> st_ff.cmp_f[0])
        else $error("compare match did not set flag");

    a_low_byte_hold: assert property (
        clk_en && st_ff.cnt_lock && !(rd_done && a == A_CNT_LO)
        |=> st_ff.cnt_lock && $stable(st_ff.cnt_buf))
        else $error("buffered low byte changed");

    a_compare_hw_safe: assert property (
        clk_en && !wr_done |=> $stable(st_ff.cmp))
        else $error("compare register changed by hardware");

    a_opm_no_cap1: assert property (
        st_ff.ctl2[C2_OPM] |-> !cap_ev[0])
        else $error("channel one captured in one-pulse mode");

endmodule

// >>> hw/frt_pkg.sv
// Purpose: constants and types of the free-running timer block
// Assumes: APB slave with 32-bit data, one byte register per word
// Notes:   all state of the timer core is carried in frt_state_s
// What this block does
// - 16-bit up-counter and its alternate copy reset to FFFCh, any mode.
// - Writing either counter low byte reloads the counter with FFFCh.
// - Clock select picks CPU clock divided by 2, 4, 8 or external.
// - Clock select value 11 picks the external clock input.
// - Edge select bit picks rising or falling external clock edge.
// - Counter updates are synchronous to the CPU clock.
// - High byte read first latches low byte until low byte is read.
// - Low byte read alone, after a pair, returns the live count.
// - Counter wrap from FFFFh to 0000h sets the overflow flag.
// - Overflow interrupts only when enabled and CPU mask clear.
// - Overflow flag clears after status read then counter low access.
// - Alternate counter low access never clears the overflow flag.
// - Counter runs in wait, stops in halt, resumes from held value.
// - Two capture registers latch the count on the chosen pin edge.
// - Capture sets its flag; shared enable and mask gate interrupt.
// - Capture flag clears after status read then capture low access.
// - Capture high read blocks captures and flag until low read.
// - In one-pulse or PWM operation only capture two works.
// - Capture pins always feed the timer, whatever the pin direction.
// - Compare registers match the count each tick; flag, pin, irq.
// - Compare registers change only by software; reset gives 8000h.
package frt_pkg;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [7:0] A_CTL1   = 8'h00; // timer_control_first
    localparam logic [7:0] A_CTL2   = 8'h04; // timer_control_second
    localparam logic [7:0] A_STAT   = 8'h08; // timer_status_reg
    localparam logic [7:0] A_CNT_HI = 8'h0C;
    localparam logic [7:0] A_CNT_LO = 8'h10;
    localparam logic [7:0] A_ALT_HI = 8'h14;
    localparam logic [7:0] A_ALT_LO = 8'h18;
    localparam logic [7:0] A_CAP_HI = 8'h1C; // channel i at +8*i
    localparam logic [7:0] A_CAP_LO = 8'h20;
    localparam logic [7:0] A_CMP_HI = 8'h2C; // channel i at +8*i
    localparam logic [7:0] A_CMP_LO = 8'h30;
    localparam logic [7:0] A_CH_STEP = 8'h08;

    // ****************************************************************
    // Field positions and codes
    // ****************************************************************
    localparam int C1_CAP_IE = 7;  // capture_irq_enable
    localparam int C1_CMP_IE = 6;  // compare_irq_enable
    localparam int C1_OVF_IE = 5;  // overflow_irq_enable
    localparam int C1_LVL2   = 2;
    localparam int C1_EDGE1  = 1;  // capture_edge_select, channel 1
    localparam int C1_LVL1   = 0;
    localparam int C2_PEN1   = 7;
    localparam int C2_PEN2   = 6;
    localparam int C2_OPM    = 5;  // one_pulse_select
    localparam int C2_PWM    = 4;
    localparam int C2_CS_LO  = 2;  // clock_select [3:2]
    localparam int C2_EDGE2  = 1;
    localparam int C2_EXEDGE = 0;  // ext_clock_edge_select
    localparam int S_CAPF1   = 7;
    localparam int S_CMPF1   = 6;
    localparam int S_OVF     = 5;
    localparam int S_CAPF2   = 4;
    localparam int S_CMPF2   = 3;
    localparam logic [1:0] CS_DIV2 = 2'h0;
    localparam logic [1:0] CS_DIV4 = 2'h1;
    localparam logic [1:0] CS_DIV8 = 2'h2;
    localparam logic [1:0] CS_EXT  = 2'h3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] CNT_RST = 16'hFFFC;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;
    localparam logic [15:0] CMP_RST = 16'h8000;

    // ****************************************************************
    // Carriers and state
    // ****************************************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } frt_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } frt_apb_rsp_s;

    typedef struct packed {
        frt_apb_rsp_s    rsp;
        logic [7:0]      ctl1;
        logic [7:0]      ctl2;
        logic [15:0]     cnt;
        logic [15:0]     snap;
        logic [2:0]      presc;
        logic [7:0]      cnt_buf;
        logic            cnt_lock;
        logic [7:0]      alt_buf;
        logic            alt_lock;
        logic            ovf;
        logic            ovf_arm;
        logic [1:0][15:0] cap;
        logic [1:0]      cap_lock;
        logic [1:0]      cap_f;
        logic [1:0]      cap_arm;
        logic [1:0][15:0] cmp;
        logic [1:0]      cmp_inh;
        logic [1:0]      cmp_f;
        logic [1:0]      cmp_arm;
        logic [1:0]      pin;
        logic            irq;
        logic [2:0]      ext_s;
        logic [1:0][2:0] cap_s;
    } frt_state_s;

    localparam frt_state_s ST_RST = '{cnt: CNT_RST,
                                      cmp: {CMP_RST, CMP_RST},
                                      default: '0};

endpackage

// >>> sim/frt_tb.sv
// Purpose: self-checking bench for the free-running timer over APB
// Assumes: one-wait-state APB slave, pins synchronised inside the timer
// Notes:   halt_mode freezes the count so exact values can be compared
`timescale 1ns/1ps

module testbench;
    import frt_pkg::*;

    // ****************************************************************
    // Signals and clock
    // ****************************************************************
    logic         pclk;
    logic         presetn;
    logic         clk_en;
    frt_apb_req_s req;
    frt_apb_rsp_s rsp;
    logic         mask;
    logic         halt;
    logic         ext;
    logic [1:0]   cap_pin;
    logic [1:0]   cmp_pin;
    logic         irq;
    int           n_fail;
    int           checks_done;
    int           cyc;
    logic         last_err;
    logic [15:0]  cnt_e;

    frt_timer dut (
        .pclk          (pclk),
        .presetn       (presetn),
        .clk_en        (clk_en),
        .apb_req       (req),
        .apb_rsp       (rsp),
        .cpu_irq_mask  (mask),
        .halt_mode     (halt),
        .ext_clock_pin (ext),
        .capture_pin   (cap_pin),
        .compare_pin   (cmp_pin),
        .timer_irq     (irq)
    );

    // Free-running 10 MHz clock
    always #50 pclk = ~pclk;

    // Cycle ceiling cuts a hang short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Request is held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge pclk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        q        = rsp.prdata[7:0];
        last_err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        apb(1'b0, a, 8'h00, q);
    endtask

    // High byte first, as a 16-bit read must be
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        logic [7:0] h;
        logic [7:0] l;
        rd(a, h);
        rd(a + 8'h04, l);
        v = {h, l};
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            ext <= 1'b1;
            repeat (6) @(posedge pclk);
            ext <= 1'b0;
            repeat (6) @(posedge pclk);
        end
        cnt_e = cnt_e + n[15:0];
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        logic [15:0] v;
        rd16(A_CNT_HI, v);
        chk("count rst", v, CNT_RST);
        rd16(A_ALT_HI, v);
        chk("alt rst", v, CNT_RST);
        rd16(A_CMP_HI, v);
        chk("cmp1 rst", v, CMP_RST);
        rd16(A_CMP_HI + A_CH_STEP, v);
        chk("cmp2 rst", v, CMP_RST);
    endtask

    // Rate per divider, counted from a low-byte reload; each one wraps
    task automatic t_rate();
        logic [15:0] v;
        logic [15:0] w;
        logic [15:0] d;
        for (int cs = 0; cs < 3; cs++) begin
            wr(A_CTL2, 8'(cs << C2_CS_LO));
            halt <= 1'b0;
            wr(A_CNT_LO, 8'h00);
            repeat (400) @(posedge pclk);
            halt <= 1'b1;
            rd16(A_CNT_HI, v);
            d = v - (CNT_RST + 16'(400 / (2 << cs))) + 16'h0002;
            chk("rate", {15'h0000, d <= 16'h0004}, 16'h0001);
            repeat (50) @(posedge pclk);
            rd16(A_CNT_HI, w);
            chk("halt", w, v);
        end
    endtask

    task automatic t_latch();
        logic [7:0] h;
        logic [7:0] l1;
        logic [7:0] l2;
        logic [7:0] l3;
        halt <= 1'b0;
        rd(A_CNT_HI, h);
        // Divider is /8 here: 112 cycles give 14 ticks, 24 give 3
        repeat (100) @(posedge pclk);
        rd(A_CNT_HI, h);
        rd(A_CNT_LO, l1);
        rd(A_CNT_LO, l2);
        repeat (20) @(posedge pclk);
        rd(A_CNT_LO, l3);
        halt <= 1'b1;
        chk("latched", {15'h0000, (l2 - l1) >= 8'd10}, 16'h0001);
        chk("live", {15'h0000, (l3 - l2) >= 8'd2 &&
                     (l3 - l2) <= 8'd4}, 16'h0001);
    endtask

    task automatic t_ovf();
        logic [7:0] s;
        mask <= 1'b1;
        wr(A_CTL1, 8'h20);
        repeat (3) @(posedge pclk);
        chk("irq masked", {15'h0000, irq}, 16'h0000);
        mask <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("irq pending", {15'h0000, irq}, 16'h0001);
        rd(A_CNT_LO, s);
        rd(A_STAT, s);
        chk("ovf set", {15'h0000, s[S_OVF]}, 16'h0001);
        rd(A_ALT_LO, s);
        rd(A_STAT, s);
        chk("ovf alt", {15'h0000, s[S_OVF]}, 16'h0001);
        rd(A_CNT_LO, s);
        rd(A_STAT, s);
        chk("ovf clr", {15'h0000, s[S_OVF]}, 16'h0000);
        chk("irq clr", {15'h0000, irq}, 16'h0000);
    endtask

    task automatic t_ext();
        logic [15:0] v;
        wr(A_CTL2, 8'h0D);
        wr(A_CNT_LO, 8'h00);
        halt  <= 1'b0;
        cnt_e = CNT_RST;
        pulse(5);
        rd16(A_CNT_HI, v);
        chk("ext rise", v, cnt_e);
        // Frozen block must miss edges while the enable is low
        clk_en <= 1'b0;
        pulse(2);
        clk_en <= 1'b1;
        cnt_e = cnt_e - 16'h0002;
        wr(A_CTL2, 8'h0C);
        pulse(3);
        rd16(A_CNT_HI, v);
        chk("ext fall", v, cnt_e);
    endtask

    task automatic t_cap();
        logic [15:0] v;
        logic [7:0]  s;
        logic [7:0]  a;
        int          b;
        wr(A_CTL1, 8'h82);
        wr(A_CTL2, 8'h0F);
        for (int i = 0; i < 2; i++) begin
            a = A_CAP_HI + 8'(i * 8);
            b = (i == 0) ? S_CAPF1 : S_CAPF2;
            cap_pin[i] <= 1'b1;
            repeat (6) @(posedge pclk);
            rd(A_STAT, s);
            chk("cap flag", {15'h0000, s[b]}, 16'h0001);
            chk("cap irq", {15'h0000, irq}, 16'h0001);
            rd16(a, v);
            chk("cap value", v, cnt_e);
            rd(A_STAT, s);
            chk("cap clr", {15'h0000, s[b]}, 16'h0000);
            rd(a, s);
            cap_pin[i] <= 1'b0;
            pulse(1);
            cap_pin[i] <= 1'b1;
            repeat (6) @(posedge pclk);
            rd(A_STAT, s);
            chk("cap block", {15'h0000, s[b]}, 16'h0000);
            rd(a + 8'h04, s);
            chk("cap held", {8'h00, s}, {8'h00, cnt_e[7:0] - 8'h01});
            cap_pin[i] <= 1'b0;
            repeat (6) @(posedge pclk);
            cap_pin[i] <= 1'b1;
            repeat (6) @(posedge pclk);
            rd16(a, v);
            chk("cap recent", v, cnt_e);
        end
        wr(A_CTL2, 8'h2F);
        cap_pin[0] <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(A_STAT, s);
        rd(A_CAP_LO, s);
        cap_pin[0] <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(A_STAT, s);
        chk("opm cap1", {15'h0000, s[S_CAPF1]}, 16'h0000);
        // PWM alone must block channel one as well
        wr(A_CTL2, 8'h1F);
        cap_pin[0] <= 1'b0;
        repeat (6) @(posedge pclk);
        cap_pin[0] <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(A_STAT, s);
        chk("pwm cap1", {15'h0000, s[S_CAPF1]}, 16'h0000);
    endtask

    task automatic t_cmp();
        logic [15:0] v;
        logic [7:0]  s;
        wr(A_CTL1, 8'h01);
        wr(A_CTL2, 8'h8D);
        wr(A_CMP_HI, cnt_e[15:8]);
        wr(A_CMP_LO, cnt_e[7:0]);
        rd16(A_CMP_HI, v);
        chk("cmp rw", v, cnt_e);
        pulse(1);
        rd(A_STAT, s);
        chk("cmp flag", {15'h0000, s[S_CMPF1]}, 16'h0001);
        chk("cmp pin", {14'h0000, cmp_pin}, 16'h0001);
        rd(8'hFC, s);
        chk("unmapped", {7'h00, last_err, s}, 16'h0100);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        pclk        = 1'b0;
        presetn     = 1'b0;
        clk_en      = 1'b1;
        req         = '0;
        mask        = 1'b1;
        halt        = 1'b1;
        ext         = 1'b0;
        cap_pin     = 2'b00;
        n_fail      = 0;
        checks_done = 0;
        cyc         = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rate();
        t_latch();
        t_ovf();
        t_ext();
        t_cap();
        t_cmp();
        conclude();
    end

endmodule
